//--- logic/sdt_ch_seq.v
// channel sequencer: first and next enabled channel, multi-channel flag
`default_nettype none

module sdt_ch_seq #(
    parameter CH_NUM = 8,
    parameter CH_W   = 3
) (
    input  wire [CH_NUM-1:0] enMask,
    input  wire [CH_W-1:0]   curCh,
    output reg  [CH_W-1:0]   firstCh,
    output reg  [CH_W-1:0]   nextCh,
    output reg               multi
);

integer i;
integer k;
integer idx;
integer cnt;

always @* begin
    firstCh = {CH_W{1'b0}};
    nextCh  = curCh;
    multi   = 1'b0;
    cnt     = 0;
    idx     = 0;
    for (i = CH_NUM - 1; i >= 0; i = i - 1) begin
        if (enMask[i]) begin
            firstCh = i[CH_W-1:0];
            cnt     = cnt + 1;
        end
    end
    // search downward so the nearest channel after the current one wins
    for (k = CH_NUM; k >= 1; k = k - 1) begin
        idx = (curCh + k) % CH_NUM;
        if (enMask[idx]) begin
            nextCh = idx[CH_W-1:0];
        end
    end
    multi = (cnt > 1);
end

endmodule
`default_nettype wire

//--- logic/sdt_defines.vh
// constants for the sinc decimator conversion timing block
`ifndef SDT_DEFINES_VH
`define SDT_DEFINES_VH

// ==========================================================================
// clocks
`define SDT_CORE_CLK_HZ     64'd250000000
`define SDT_MCLK_FULL_HZ    64'd614400
`define SDT_MCLK_MID_HZ     64'd153600
`define SDT_MCLK_LOW_HZ     64'd76800
`define SDT_PWR_FULL        2'h0
`define SDT_PWR_MID         2'h1

// ==========================================================================
// timing counts in master clock cycles, decimation shift and 50 Hz divider settings
`define SDT_DEC_SHIFT       5
`define SDT_DEAD_FS1        19'h0003d
`define SDT_DEAD_FSN        19'h0005f
`define SDT_SEQ_SAME        19'h0001e
`define SDT_SEQ_TO1         19'h00004
`define SDT_SEQ_FROM1       19'h00040
`define SDT_NOTCH50_FULL    11'h180
`define SDT_NOTCH50_MID     11'h060
`define SDT_NOTCH50_LOW     11'h030

// ==========================================================================
// register map and fields
`define SDT_ADDR_CTRL       8'h00
`define SDT_ADDR_STATUS     8'h04
`define SDT_ADDR_CHCFG      3'h1
`define SDT_CTRL_RUN        0
`define SDT_CTRL_PWR_LO     1
`define SDT_CTRL_MASK_LO    8
`define SDT_STAT_ERR        4
`define SDT_CFG_SINC3       16
`define SDT_CFG_ZL          17
`define SDT_CFG_SIXTY_HZ_NOTCH_ENABLE       18
`define SDT_FS_RESET        11'h180
`define SDT_SINC3_RESET     1'h0

`endif

//--- logic/sdt_mclk_div.v
// master clock enable generator, fractional divider from the core clock
`default_nettype none
`include "sdt_defines.vh"

module sdt_mclk_div (
    input  wire       core_clk,
    input  wire       rst_b,
    input  wire [1:0] powerMode,
    output reg        mclkEn
);

// ==========================================================================
// phase increments
// a phase accumulator is used because 250 MHz is no integer multiple of the rates
localparam [63:0] INC_FULL_W = (`SDT_MCLK_FULL_HZ * 64'h100000000) / `SDT_CORE_CLK_HZ;
localparam [63:0] INC_MID_W  = (`SDT_MCLK_MID_HZ * 64'h100000000) / `SDT_CORE_CLK_HZ;
localparam [63:0] INC_LOW_W  = (`SDT_MCLK_LOW_HZ * 64'h100000000) / `SDT_CORE_CLK_HZ;

reg  [31:0] phase_reg;
reg  [31:0] inc;
wire [32:0] phaseSum;

always @* begin
    if (powerMode == `SDT_PWR_FULL) begin
        inc = INC_FULL_W[31:0];
    end else if (powerMode == `SDT_PWR_MID) begin
        inc = INC_MID_W[31:0];
    end else begin
        inc = INC_LOW_W[31:0];
    end
end

assign phaseSum = {1'b0, phase_reg} + {1'b0, inc};

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        phase_reg <= 32'h0;
        mclkEn    <= 1'b0;
    end else begin
        phase_reg <= phaseSum[31:0];
        mclkEn    <= phaseSum[32];
    end
end

endmodule
`default_nettype wire

//--- logic/sdt_timing.v
// conversion timing of the sinc decimator with apb register slave
`default_nettype none
`include "sdt_defines.vh"

module sdt_timing #(
    parameter CH_NUM = 8,
    parameter CH_W   = 3
) (
    input  wire              core_clk,
    input  wire              rst_b,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    input  wire              stepIn,
    output reg               modReset,
    output reg               resultValid,
    output reg               resultSettled,
    output reg  [CH_W-1:0]   resultChannel,
    output reg               sinc3Active,
    output reg               zeroLatActive,
    output reg               notch60Active
);

// ==========================================================================
// states
localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_CONV = 2'b10;

// ==========================================================================
// functions
function [18:0] convLen;
    input [10:0] fs;
    input        s3;
    reg   [18:0] base;
    begin
        base = {8'h00, fs} << `SDT_DEC_SHIFT;
        if (s3) begin
            convLen = base + (base << 1);
        end else begin
            convLen = base << 2;
        end
    end
endfunction

function [18:0] firstSettle;
    input [10:0] fs;
    input        s3;
    begin
        if (fs == 11'h001) begin
            firstSettle = convLen(fs, s3) + `SDT_DEAD_FS1;
        end else begin
            firstSettle = convLen(fs, s3) + `SDT_DEAD_FSN;
        end
    end
endfunction

function isCfgAddr;
    input [7:0] addr;
    begin
        isCfgAddr = (addr[7:5] == `SDT_ADDR_CHCFG) && (addr[1:0] == 2'h0);
    end
endfunction

// ==========================================================================
// register storage
reg              ctrlRun_reg;
reg  [1:0]       powerMode_reg;
reg  [CH_NUM-1:0] enMask_reg;
reg              cfgErr_reg;
reg  [10:0]      chFs_reg [0:CH_NUM-1];
reg  [CH_NUM-1:0] chSinc3_reg;
reg  [CH_NUM-1:0] chZl_reg;
reg  [CH_NUM-1:0] chRej_reg;

// ==========================================================================
// engine state
reg  [1:0]       state_reg;
reg  [18:0]      cnt_reg;
reg  [CH_W-1:0]  curCh_reg;
reg  [10:0]      curFs_reg;
reg              curSinc3_reg;
reg              curZl_reg;
reg              curRej_reg;
reg  [2:0]       unsettled_reg;
reg  [15:0]      resultCount_reg;
reg              restartReq_reg;

wire             mclkEn;
wire [CH_W-1:0]  firstCh;
wire [CH_W-1:0]  nextCh;
wire             multi;

// ==========================================================================
// sub-blocks
sdt_mclk_div u_div (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .powerMode (powerMode_reg),
    .mclkEn    (mclkEn)
);

sdt_ch_seq #(
    .CH_NUM (CH_NUM),
    .CH_W   (CH_W)
) u_seq (
    .enMask  (enMask_reg),
    .curCh   (curCh_reg),
    .firstCh (firstCh),
    .nextCh  (nextCh),
    .multi   (multi)
);

// ==========================================================================
// apb decode
wire            apbSetup  = psel & penable & ~pready;
wire            apbDone   = psel & penable & pready;
wire            hitCtrl   = (paddr == `SDT_ADDR_CTRL);
wire            hitStatus = (paddr == `SDT_ADDR_STATUS);
wire            hitCfg    = isCfgAddr(paddr);
wire [CH_W-1:0] cfgIdx    = paddr[CH_W+1:2];
wire            addrOk    = hitCtrl | hitStatus | hitCfg;
wire            apbWr     = apbDone & pwrite & addrOk;
wire            cfgWr     = apbWr & isCfgAddr(paddr);
wire            fsZeroWr  = cfgWr & (pwdata[10:0] == 11'h000);
wire            cfgTouch  = apbWr & (hitCtrl | (hitCfg & (cfgIdx == curCh_reg)));
wire            effZl     = curZl_reg | multi;
wire            resultEvt = (state_reg == ST_CONV) & mclkEn & (cnt_reg == 19'h00001);
reg  [31:0]     rdMux;
reg  [10:0]     notchFs;

always @* begin
    rdMux = 32'h0;
    if (hitCtrl) begin
        rdMux = {16'h0, enMask_reg, 5'h0, powerMode_reg, ctrlRun_reg};
    end else if (hitStatus) begin
        rdMux = {resultCount_reg, 10'h0, resultSettled, cfgErr_reg,
                 state_reg == ST_CONV, curCh_reg};
    end else if (hitCfg) begin
        rdMux = {13'h0, chRej_reg[cfgIdx], chZl_reg[cfgIdx], chSinc3_reg[cfgIdx],
                 5'h0, chFs_reg[cfgIdx]};
    end
end

always @* begin
    if (powerMode_reg == `SDT_PWR_FULL) begin
        notchFs = `SDT_NOTCH50_FULL;
    end else if (powerMode_reg == `SDT_PWR_MID) begin
        notchFs = `SDT_NOTCH50_MID;
    end else begin
        notchFs = `SDT_NOTCH50_LOW;
    end
end

// ==========================================================================
// apb slave: one wait state, answer registered
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        pready  <= 1'b0;
        prdata  <= 32'h0;
        pslverr <= 1'b0;
    end else begin
        pready  <= apbSetup;
        // the error flag stands only with its ready, never past the access
        pslverr <= apbSetup & ~addrOk;
        if (apbSetup) begin
            prdata  <= pwrite ? 32'h0 : rdMux;
        end
    end
end

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        ctrlRun_reg   <= 1'b0;
        powerMode_reg <= `SDT_PWR_FULL;
        enMask_reg    <= {CH_NUM{1'b0}};
        cfgErr_reg    <= 1'b0;
    end else begin
        if (apbWr && hitCtrl) begin
            ctrlRun_reg   <= pwdata[`SDT_CTRL_RUN];
            powerMode_reg <= pwdata[`SDT_CTRL_PWR_LO+1:`SDT_CTRL_PWR_LO];
            enMask_reg    <= pwdata[`SDT_CTRL_MASK_LO+CH_NUM-1:`SDT_CTRL_MASK_LO];
        end
        // a new zero write wins over a clear in the same cycle
        if (fsZeroWr) begin
            cfgErr_reg <= 1'b1;
        end else if (apbWr && hitStatus && pwdata[`SDT_STAT_ERR]) begin
            cfgErr_reg <= 1'b0;
        end
    end
end

genvar g;
generate
    for (g = 0; g < CH_NUM; g = g + 1) begin : gCh
        always @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                chFs_reg[g]    <= `SDT_FS_RESET;
                chSinc3_reg[g] <= `SDT_SINC3_RESET;
                chZl_reg[g]    <= 1'b0;
                chRej_reg[g]   <= 1'b0;
            end else if (cfgWr && cfgIdx == g) begin
                // a zero divider is refused and the old value kept
                if (!fsZeroWr) begin
                    chFs_reg[g] <= pwdata[10:0];
                end
                chSinc3_reg[g] <= pwdata[`SDT_CFG_SINC3];
                chZl_reg[g]    <= pwdata[`SDT_CFG_ZL];
                chRej_reg[g]   <= pwdata[`SDT_CFG_SIXTY_HZ_NOTCH_ENABLE];
            end
        end
    end
endgenerate

// ==========================================================================
// conversion engine, counts master clock enables
reg [18:0] seqLen;
reg [10:0] nFs;
reg        nS3;

always @* begin
    nFs = chFs_reg[nextCh];
    nS3 = chSinc3_reg[nextCh];
    if ((curFs_reg == 11'h001) == (nFs == 11'h001)) begin
        seqLen = convLen(nFs, nS3) + `SDT_SEQ_SAME;
    end else if (nFs == 11'h001) begin
        seqLen = convLen(nFs, nS3) - `SDT_SEQ_TO1;
    end else begin
        seqLen = convLen(nFs, nS3) + `SDT_SEQ_FROM1;
    end
end

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        state_reg       <= ST_IDLE;
        cnt_reg         <= 19'h0;
        curCh_reg       <= {CH_W{1'b0}};
        curFs_reg       <= `SDT_FS_RESET;
        curSinc3_reg    <= `SDT_SINC3_RESET;
        curZl_reg       <= 1'b0;
        curRej_reg      <= 1'b0;
        unsettled_reg   <= 3'h0;
        resultCount_reg <= 16'h0;
        restartReq_reg  <= 1'b0;
        modReset        <= 1'b0;
        resultValid     <= 1'b0;
        resultSettled   <= 1'b0;
        resultChannel   <= {CH_W{1'b0}};
    end else begin
        resultValid    <= 1'b0;
        modReset       <= 1'b0;
        restartReq_reg <= cfgTouch;
        if (!ctrlRun_reg || enMask_reg == {CH_NUM{1'b0}}) begin
            state_reg <= ST_IDLE;
        end else if (restartReq_reg || state_reg == ST_IDLE) begin
            // manual channel change: settings sampled, full settling
            state_reg     <= ST_CONV;
            curCh_reg     <= firstCh;
            curFs_reg     <= chFs_reg[firstCh];
            curSinc3_reg  <= chSinc3_reg[firstCh];
            curZl_reg     <= chZl_reg[firstCh];
            curRej_reg    <= chRej_reg[firstCh];
            cnt_reg       <= firstSettle(chFs_reg[firstCh], chSinc3_reg[firstCh]);
            modReset      <= 1'b1;
            unsettled_reg <= 3'h0;
        end else if (resultEvt) begin
            resultValid     <= 1'b1;
            resultChannel   <= curCh_reg;
            resultSettled   <= (unsettled_reg == 3'h0);
            resultCount_reg <= resultCount_reg + 16'h0001;
            if (multi) begin
                // each switch gets a fresh settling, so steps never leak through
                curCh_reg     <= nextCh;
                curFs_reg     <= nFs;
                curSinc3_reg  <= nS3;
                curZl_reg     <= chZl_reg[nextCh];
                curRej_reg    <= chRej_reg[nextCh];
                cnt_reg       <= seqLen;
                modReset      <= 1'b1;
                unsettled_reg <= 3'h0;
            end else begin
                if (curZl_reg) begin
                    cnt_reg <= convLen(curFs_reg, curSinc3_reg);
                end else begin
                    cnt_reg <= {8'h00, curFs_reg} << `SDT_DEC_SHIFT;
                end
                if (stepIn) begin
                    // step on a conversion boundary
                    if (curZl_reg) begin
                        unsettled_reg <= 3'h0;
                    end else begin
                        unsettled_reg <= curSinc3_reg ? 3'h2 : 3'h3;
                    end
                end else if (unsettled_reg != 3'h0) begin
                    unsettled_reg <= unsettled_reg - 3'h1;
                end
            end
        end else begin
            if (state_reg == ST_CONV && mclkEn) begin
                cnt_reg <= cnt_reg - 19'h00001;
            end
            if (stepIn && state_reg == ST_CONV && !multi) begin
                // step inside a conversion costs one more result
                if (curZl_reg) begin
                    unsettled_reg <= 3'h1;
                end else begin
                    unsettled_reg <= curSinc3_reg ? 3'h3 : 3'h4;
                end
            end
        end
    end
end

// ==========================================================================
// mode indications
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        sinc3Active   <= 1'b0;
        zeroLatActive <= 1'b0;
        notch60Active <= 1'b0;
    end else begin
        sinc3Active   <= curSinc3_reg;
        zeroLatActive <= effZl & (state_reg == ST_CONV);
        // the extra notch only applies where the sinc notch lands on 50 Hz
        notch60Active <= curRej_reg & (curFs_reg == notchFs);
    end
end

endmodule
`default_nettype wire

//--- verif/sdt_step_src.sv
// partner model: analog input step source in front of the modulator
`default_nettype none
module sdt_step_src (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic asyncReq,
    output logic     stepIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // a step lands off the result edges, so it is asynchronous to conversions
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) stepIn <= 1'b0;
        else stepIn <= asyncReq;
    end
endmodule
`default_nettype wire

//--- verif/sdt_timing_chk.sv
// assertion checker for the sinc decimator conversion timing block
`default_nettype none
module sdt_timing_chk #(
    parameter int CH_NUM = 8,
    parameter int CH_W   = 3
) (
    input wire logic            core_clk,
    input wire logic            rst_b,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            stepIn,
    input wire logic            modReset,
    input wire logic            resultValid,
    input wire logic            resultSettled,
    input wire logic [CH_W-1:0] resultChannel,
    input wire logic            sinc3Active,
    input wire logic            zeroLatActive,
    input wire logic            notch60Active
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // helper counters
    // the settle bound sits over one master period low, the gap bound less than one: the first enable after a restart has free phase
    localparam int SETTLE_MIN = 63000;
    localparam int GAP_MIN    = 12900;
    logic [16:0] gapCnt;
    logic        firstPend;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gapCnt    <= 17'h00000;
            firstPend <= 1'b0;
        end else begin
            if (resultValid || modReset) gapCnt <= 17'h00000;
            else if (gapCnt != 17'h1ffff) gapCnt <= gapCnt + 17'h00001;
            if (modReset && !resultValid) firstPend <= 1'b1;
            else if (resultValid) firstPend <= 1'b0;
        end
    end
    // =====================================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence apbWait;
        psel && penable && !pready;
    endsequence
    ready_wait_a: assert property (apbSetup ##1 apbWait |=> pready)
        else $error("bus answer not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("bus ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("bus error without ready");
    write_zero_a: assert property (pready && pwrite |-> prdata == 32'h00000000)
        else $error("read data not zero on write");
    valid_pulse_a: assert property (resultValid |=> !resultValid)
        else $error("result strobe longer than one cycle");
    reset_pulse_a: assert property (modReset |=> !modReset)
        else $error("filter reset longer than one cycle");
    settle_min_a: assert property (resultValid && firstPend |-> gapCnt >= SETTLE_MIN)
        else $error("first result before full settling");
    period_min_a: assert property (resultValid && !firstPend |-> gapCnt >= GAP_MIN)
        else $error("results closer than one output period");
    channel_hold_a: assert property (!resultValid |-> $stable(resultChannel))
        else $error("result channel moved without a result");
    settled_hold_a: assert property (!resultValid |-> $stable(resultSettled))
        else $error("settled flag moved without a result");
endmodule
`default_nettype wire

//--- verif/sinc3_decimator_timing_test.sv
// self-checking bench of the sinc decimator conversion timing block
`default_nettype none
module sinc3_decimator_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam real PER    = 250.0e6 / 614400.0;
    localparam int  SETTLE = 3 * 32 * 1 + 61;
    localparam int  LO1    = int'((SETTLE - 1) * PER) - 3;
    localparam int  HI1    = int'(SETTLE * PER) + 3;
    localparam int  LO2    = int'(32 * PER) - 3;
    localparam int  HI2    = int'(32 * PER) + 3;
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h00000000;
    logic        asyncReq = 1'b0;
    wire  [31:0] prdata;
    wire  [2:0]  resultChannel;
    wire         pready, pslverr, stepIn, modReset, resultValid;
    wire         resultSettled, sinc3Active, zeroLatActive, notch60Active;
    int          errorCnt   = 0;
    int          checkCount = 0;
    int          cycles     = 0;

    always #2 core_clk = ~core_clk;

    sdt_timing #(.CH_NUM(8), .CH_W(3)) DUT (
        .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stepIn(stepIn), .modReset(modReset),
        .resultValid(resultValid), .resultSettled(resultSettled),
        .resultChannel(resultChannel), .sinc3Active(sinc3Active),
        .zeroLatActive(zeroLatActive), .notch60Active(notch60Active));
    sdt_step_src STEP (.core_clk(core_clk), .rst_b(rst_b), .asyncReq(asyncReq),
        .stepIn(stepIn));

    // =====================================================================
    // shared tasks
    task automatic giveVerdict;
        if (errorCnt == 0 && checkCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h00000000, r, e);
        check({31'h0, e}, 32'h0);
        check(r, exp);
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask
    task automatic toResult(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (resultValid !== 1'b1 && n < 70000);
    endtask

    // =====================================================================
    // scenarios
    task automatic resetValues;
        rdChk(8'h00, 32'h00000000);
        rdChk(8'h20, 32'h00000180);
        rdChk(8'h3c, 32'h00000180);
        rdChk(8'h04, 32'h00000000);
    endtask
    task automatic unmappedAccess;
        logic [31:0] r;
        logic        e;
        apb(1'b0, 8'h1c, 32'h00000000, r, e);
        check({31'h0, e}, 32'h1);
        check(r, 32'h00000000);
        apb(1'b1, 8'hfc, 32'hffffffff, r, e);
        check({31'h0, e}, 32'h1);
        rdChk(8'h00, 32'h00000000);
    endtask
    task automatic zeroDivider;
        wrReg(8'h20, 32'h00010000);
        rdChk(8'h20, 32'h00010180);
        rdChk(8'h04, 32'h00000010);
        wrReg(8'h04, 32'h00000010);
        rdChk(8'h04, 32'h00000000);
        wrReg(8'h20, 32'h00000180);
    endtask
    task automatic modeFlags;
        wrReg(8'h20, 32'h00060180);
        wrReg(8'h00, 32'h00000101);
        repeat (5) @(posedge core_clk);
        check({31'h0, notch60Active}, 32'h1);
        check({31'h0, zeroLatActive}, 32'h1);
        check({31'h0, sinc3Active}, 32'h0);
        wrReg(8'h20, 32'h00000180);
        wrReg(8'h00, 32'h00000301);
        repeat (5) @(posedge core_clk);
        check({31'h0, zeroLatActive}, 32'h1);
        check({31'h0, notch60Active}, 32'h0);
        // mid power moves the 50 Hz divider setting down to 96
        wrReg(8'h20, 32'h00040060);
        wrReg(8'h00, 32'h00000103);
        repeat (5) @(posedge core_clk);
        check({31'h0, notch60Active}, 32'h1);
        check({31'h0, zeroLatActive}, 32'h0);
        wrReg(8'h00, 32'h00000000);
    endtask
    // the step goes in mid-conversion, so three unsettled results follow
    task automatic mainTiming;
        int n;
        wrReg(8'h20, 32'h00010001);
        wrReg(8'h00, 32'h00000101);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (modReset !== 1'b1 && n < 20);
        check({31'h0, modReset}, 32'h1);
        toResult(n);
        check({31'h0, n >= LO1 && n <= HI1}, 32'h1);
        check({31'h0, sinc3Active}, 32'h1);
        check({31'h0, resultSettled}, 32'h1);
        check({29'h0, resultChannel}, 32'h0);
        repeat (100) @(posedge core_clk);
        asyncReq <= 1'b1;
        @(posedge core_clk);
        asyncReq <= 1'b0;
        toResult(n);
        check({31'h0, n + 101 >= LO2 && n + 101 <= HI2}, 32'h1);
        check({31'h0, resultSettled}, 32'h0);
        rdChk(8'h04, 32'h00020008);
        wrReg(8'h00, 32'h00000000);
    endtask

    // =====================================================================
    // run control
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            errorCnt++;
            giveVerdict();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        resetValues();
        unmappedAccess();
        zeroDivider();
        modeFlags();
        mainTiming();
        giveVerdict();
    end
endmodule

bind sdt_timing sdt_timing_chk #(.CH_NUM(CH_NUM), .CH_W(CH_W)) CHK (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stepIn(stepIn), .modReset(modReset),
    .resultValid(resultValid), .resultSettled(resultSettled),
    .resultChannel(resultChannel), .sinc3Active(sinc3Active),
    .zeroLatActive(zeroLatActive), .notch60Active(notch60Active));
`default_nettype wire
